// ---- arb_dev.sv ----
// Host bridge end: arbitration, hold handshake, lock, parity check, error,
// clock keepalive and memory claim.
// Assumes: one clock; sys_rst acts at once on all pin enables.
`timescale 1ns/1ns
module arb_dev #(
    parameter int NUM_MASTERS = arb_pkg::NUM_MASTERS
) (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    arb_link_if.dev   link,
    input  wire logic cpu_lock_req,
    input  wire logic cpu_stop_req,
    input  wire logic clock_needed,
    output logic      wr_buf_empty,
    output logic      post_buf_empty,
    output logic      hold_active,
    output logic      parity_error
);

    ////////////////////////////////////////////////////////////////////////
    // State
    arb_pkg::hold_state_t hold_reg, hold_next;
    logic [7:0]           cnt_reg, cnt_next;
    logic [4:0]           gnt_reg, gnt_next;
    logic [2:0]           last_reg, last_next;
    logic                 lock_reg, lock_next;
    logic                 stop_reg, stop_next;
    logic [7:0]           keep_reg, keep_next;
    logic                 par_exp_reg, par_exp_next;
    logic                 chk_reg, chk_next;
    logic                 serr_reg, serr_next;
    logic [1:0]           dsel_reg, dsel_next;
    logic                 perr_reg, perr_next;
    logic                 out_en_reg;

    ////////////////////////////////////////////////////////////////////////
    // Hold handshake and arbitration next state
    always_comb begin
        logic [4:0] req;
        logic [2:0] idx;
        hold_next = hold_reg;
        cnt_next  = cnt_reg;
        gnt_next  = arb_pkg::GNT_IDLE;
        last_next = last_reg;
        req       = ~link.req_n;
        idx       = 3'h0;
        unique case (hold_reg)
            arb_pkg::HOLD_IDLE: begin
                if (!link.bridge_hold_req_n) begin
                    hold_next = arb_pkg::HOLD_DRAIN_WR;
                    cnt_next  = arb_pkg::DRAIN_CYCLES;
                end
            end
            arb_pkg::HOLD_DRAIN_WR: begin
                cnt_next = cnt_reg - 8'h01;
                if (cnt_reg == 8'h01) begin
                    hold_next = arb_pkg::HOLD_DRAIN_PO;
                    cnt_next  = arb_pkg::DRAIN_CYCLES;
                end
            end
            arb_pkg::HOLD_DRAIN_PO: begin
                cnt_next = cnt_reg - 8'h01;
                if (cnt_reg == 8'h01) begin
                    hold_next = arb_pkg::HOLD_ACQUIRE;
                    cnt_next  = arb_pkg::ACQUIRE_CYCLES;
                end
            end
            arb_pkg::HOLD_ACQUIRE: begin
                // Count stops at one so a late grant cannot wrap the wait
                if (cnt_reg != 8'h01) begin
                    cnt_next = cnt_reg - 8'h01;
                end
                if (cnt_reg == 8'h01 && gnt_reg == arb_pkg::GNT_IDLE) begin
                    hold_next = arb_pkg::HOLD_GRANTED;
                end
            end
            arb_pkg::HOLD_GRANTED: begin
                // Release when request drops; passive release keeps buffers drained
                if (link.bridge_hold_req_n) begin
                    hold_next = arb_pkg::HOLD_IDLE;
                end
            end
            default: hold_next = arb_pkg::HOLD_IDLE;
        endcase
        // Round robin, only when the hold path is idle; one grant at a time
        if (hold_reg == arb_pkg::HOLD_IDLE && link.bridge_hold_req_n) begin
            for (int i = 1; i <= NUM_MASTERS; i++) begin
                idx = 3'((int'(last_reg) + i) % NUM_MASTERS);
                if (req[idx] && gnt_next == arb_pkg::GNT_IDLE) begin
                    gnt_next       = arb_pkg::GNT_IDLE;
                    gnt_next[idx]  = 1'b0;
                    last_next      = idx;
                end
            end
            // Keep the current owner while it still requests
            if (gnt_reg != arb_pkg::GNT_IDLE && req[last_reg]) begin
                gnt_next           = arb_pkg::GNT_IDLE;
                gnt_next[last_reg] = 1'b0;
                last_next          = last_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock, stop, keepalive, parity, error and claim next state
    always_comb begin
        lock_next = cpu_lock_req;
        // Lock only marks own cycles; other masters keep being granted
        if (!cpu_lock_req) begin
            lock_next = 1'b0;
        end
        stop_next    = cpu_stop_req;
        keep_next    = keep_reg;
        if (clock_needed) begin
            keep_next = arb_pkg::KEEPALIVE_HOLD;
        end else if (keep_reg != 8'h00) begin
            keep_next = keep_reg - 8'h01;
        end
        par_exp_next = ^{link.ad, link.cbe_n};
        chk_next     = link.drive_far;
        perr_next    = chk_reg && (link.par != par_exp_reg);
        serr_next    = perr_next;
        dsel_next    = 2'h0;
        if (link.mem_access) begin
            dsel_next = dsel_reg + 2'h1;
            if (dsel_reg == arb_pkg::DEVSEL_MEDIUM) begin
                dsel_next = dsel_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            hold_reg    <= arb_pkg::HOLD_IDLE;
            cnt_reg     <= 8'h00;
            gnt_reg     <= arb_pkg::GNT_IDLE;
            last_reg    <= 3'h0;
            lock_reg    <= 1'b0;
            stop_reg    <= 1'b0;
            keep_reg    <= 8'h00;
            par_exp_reg <= 1'b0;
            chk_reg     <= 1'b0;
            serr_reg    <= 1'b0;
            dsel_reg    <= 2'h0;
            perr_reg    <= 1'b0;
            out_en_reg  <= 1'b0;
        end else begin
            hold_reg    <= hold_next;
            cnt_reg     <= cnt_next;
            gnt_reg     <= gnt_next;
            last_reg    <= last_next;
            lock_reg    <= lock_next;
            stop_reg    <= stop_next;
            keep_reg    <= keep_next;
            par_exp_reg <= par_exp_next;
            chk_reg     <= chk_next;
            serr_reg    <= serr_next;
            dsel_reg    <= dsel_next;
            perr_reg    <= perr_next;
            out_en_reg  <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive; reset gates every enable at once
    logic en;
    assign en = out_en_reg && !sys_rst;
    assign link.gnt_n              = gnt_reg;
    assign link.gnt_oe             = {NUM_MASTERS{en}};
    assign link.bridge_hold_ack_n  = (hold_reg != arb_pkg::HOLD_GRANTED);
    assign link.bridge_hold_ack_oe = en;
    assign link.stop_dev_o         = 1'b0;
    assign link.stop_dev_oe        = en && stop_reg;
    assign link.exclusive_dev_o    = 1'b0;
    assign link.exclusive_dev_oe   = en && lock_reg;
    assign link.devsel_dev_o       = 1'b0;
    assign link.devsel_dev_oe      = en && dsel_reg == arb_pkg::DEVSEL_MEDIUM;
    assign link.serr_dev_o         = 1'b0;
    assign link.serr_dev_oe        = en && serr_reg;
    assign link.keepalive_dev_o    = 1'b0;
    assign link.keepalive_dev_oe   = en && keep_reg != 8'h00;
    assign wr_buf_empty   = hold_reg inside {arb_pkg::HOLD_DRAIN_PO, arb_pkg::HOLD_ACQUIRE,
                                             arb_pkg::HOLD_GRANTED};
    assign post_buf_empty = hold_reg inside {arb_pkg::HOLD_ACQUIRE, arb_pkg::HOLD_GRANTED};
    assign hold_active    = (hold_reg == arb_pkg::HOLD_GRANTED);
    assign parity_error   = perr_reg;

endmodule : arb_dev

// ---- arb_pkg.sv ----
// Package: shared constants and types for the bus arbitration control ends.
// Assumes: both ends run on one clock, clk_sys, at 50 MHz.
package arb_pkg;
    localparam int         NUM_MASTERS    = 5;
    localparam int         AD_WIDTH       = 32;
    localparam int         CBE_WIDTH      = 4;
    localparam logic [4:0] GNT_IDLE       = 5'h1f;
    localparam logic [7:0] DRAIN_CYCLES   = 8'h04;
    localparam logic [7:0] ACQUIRE_CYCLES = 8'h02;
    localparam logic [7:0] KEEPALIVE_HOLD = 8'h08;
    localparam logic [3:0] STOP_LIMIT     = 4'h8;
    localparam logic [1:0] DEVSEL_MEDIUM  = 2'h1;

    // Hold handshake sequence
    typedef enum logic [2:0] {
        HOLD_IDLE     = 3'b000,
        HOLD_DRAIN_WR = 3'b001,
        HOLD_DRAIN_PO = 3'b011,
        HOLD_ACQUIRE  = 3'b010,
        HOLD_GRANTED  = 3'b110
    } hold_state_t;
endpackage : arb_pkg

// ---- arb_link_if.sv ----
// Interface: bus-side signals joining the host bridge end and the bus-party end.
// Assumes: the testbench resolves shared and open-drain lines from the enables.
`timescale 1ns/1ns
interface arb_link_if;
    logic [4:0]  req_n;
    logic [4:0]  gnt_n;
    logic [4:0]  gnt_oe;
    logic        bridge_hold_req_n;
    logic        bridge_hold_ack_n;
    logic        bridge_hold_ack_oe;
    logic        stop_dev_o;
    logic        stop_dev_oe;
    logic        stop_far_o;
    logic        stop_far_oe;
    logic        stop_n;
    logic        exclusive_dev_o;
    logic        exclusive_dev_oe;
    logic        exclusive_access_n;
    logic [31:0] ad_far_o;
    logic [3:0]  cbe_far_o;
    logic        par_far_o;
    logic        drive_far;
    logic [31:0] ad;
    logic [3:0]  cbe_n;
    logic        par;
    logic        mem_access;
    logic        devsel_dev_o;
    logic        devsel_dev_oe;
    logic        serr_dev_o;
    logic        serr_dev_oe;
    logic        keepalive_dev_o;
    logic        keepalive_dev_oe;
    logic        bus_clock_keepalive_n;

    modport dev (
        input  req_n, bridge_hold_req_n, stop_n, exclusive_access_n,
        input  ad, cbe_n, par, mem_access, bus_clock_keepalive_n, drive_far,
        output gnt_n, gnt_oe, bridge_hold_ack_n, bridge_hold_ack_oe,
        output stop_dev_o, stop_dev_oe, exclusive_dev_o, exclusive_dev_oe,
        output devsel_dev_o, devsel_dev_oe, serr_dev_o, serr_dev_oe,
        output keepalive_dev_o, keepalive_dev_oe
    );
    modport far (
        input  gnt_n, bridge_hold_ack_n, stop_n, exclusive_access_n, ad, cbe_n,
        input  devsel_dev_o, devsel_dev_oe, serr_dev_o, serr_dev_oe,
        output req_n, bridge_hold_req_n, stop_far_o, stop_far_oe,
        output ad_far_o, cbe_far_o, par_far_o, drive_far, mem_access
    );
endinterface : arb_link_if

// ---- arb_far.sv ----
// Bus-party end: five masters' requests, expansion bridge hold, and data drive
// with parity.
// Assumes: one clock; grants arrive from the host bridge end.
`timescale 1ns/1ns
module arb_far (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    arb_link_if.far          link,
    input  wire logic [4:0]  want_bus,
    input  wire logic        want_hold,
    input  wire logic        drive_req,
    input  wire logic [31:0] ad_in,
    input  wire logic [3:0]  cbe_in,
    input  wire logic        mem_req,
    output logic [4:0]       granted,
    output logic             hold_granted,
    output logic             stopped
);

    logic [31:0] ad_reg, ad_next;
    logic [3:0]  cbe_reg, cbe_next;
    logic        par_reg, par_next;
    logic        drv_reg, drv_next;
    logic [4:0]  gnt_reg, gnt_next;
    logic        hold_reg, hold_next;
    logic        stop_reg, stop_next;

    ////////////////////////////////////////////////////////////////////////
    // Next values: data one clock, parity the clock after
    always_comb begin
        ad_next   = ad_in;
        cbe_next  = cbe_in;
        drv_next  = drive_req;
        par_next  = ^{ad_reg, cbe_reg};
        gnt_next  = ~link.gnt_n;
        hold_next = !link.bridge_hold_ack_n;
        stop_next = !link.stop_n;
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ad_reg   <= 32'h0000_0000;
            cbe_reg  <= 4'h0;
            par_reg  <= 1'b0;
            drv_reg  <= 1'b0;
            gnt_reg  <= 5'h00;
            hold_reg <= 1'b0;
            stop_reg <= 1'b0;
        end else begin
            ad_reg   <= ad_next;
            cbe_reg  <= cbe_next;
            par_reg  <= par_next;
            drv_reg  <= drv_next;
            gnt_reg  <= gnt_next;
            hold_reg <= hold_next;
            stop_reg <= stop_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins; a stopped master drops its request
    assign link.req_n             = ~(want_bus & ~{5{stop_reg}});
    assign link.bridge_hold_req_n = !want_hold;
    assign link.stop_far_o        = 1'b0;
    assign link.stop_far_oe       = 1'b0;
    assign link.ad_far_o          = ad_reg;
    assign link.cbe_far_o         = cbe_reg;
    assign link.par_far_o         = par_reg;
    assign link.drive_far         = drv_reg;
    assign link.mem_access        = mem_req;
    assign granted                = gnt_reg;
    assign hold_granted           = hold_reg;
    assign stopped                = stop_reg;

endmodule : arb_far

// ---- arb_link_properties.sv ----
// Checker: timing relations on the link joining the two ends.
// Assumes: one clock; the testbench instantiates it beside the interface.
`timescale 1ns/1ns
module arb_link_properties (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic [4:0]  req_n,
    input wire logic [4:0]  gnt_n,
    input wire logic [4:0]  gnt_oe,
    input wire logic        bridge_hold_req_n,
    input wire logic        bridge_hold_ack_n,
    input wire logic        bridge_hold_ack_oe,
    input wire logic        drive_far,
    input wire logic [31:0] ad,
    input wire logic [3:0]  cbe_n,
    input wire logic        par_far_o,
    input wire logic        mem_access,
    input wire logic        devsel_dev_o,
    input wire logic        devsel_dev_oe,
    input wire logic        serr_dev_o,
    input wire logic        serr_dev_oe,
    input wire logic        keepalive_dev_oe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////
    // Arbitration and hold handshake
    a_one_grant: assert property ($onehot0({~gnt_n, ~bridge_hold_ack_n}))
        else $error("grants overlap");
    a_grant_requested: assert property (!(|(~gnt_n & $past(gnt_n & req_n))))
        else $error("grant without request");
    a_grant_latency: assert property ((gnt_n == 5'h1f && bridge_hold_ack_n
        && bridge_hold_req_n && $past(bridge_hold_req_n) && req_n != 5'h1f)
        |=> gnt_n != 5'h1f) else $error("grant late");
    a_hold_ack_time: assert property (($fell(bridge_hold_req_n) && gnt_n == 5'h1f)
        |-> ##10 bridge_hold_ack_n ##1 !bridge_hold_ack_n) else $error("ack timing");
    a_passive_hold: assert property (!bridge_hold_ack_n && !bridge_hold_req_n
        |=> !bridge_hold_ack_n) else $error("ack dropped early");
    // Parity, error, claim and reset float
    a_parity_even: assert property ($past(drive_far)
        |-> par_far_o == ^{$past(ad), $past(cbe_n)}) else $error("parity wrong");
    a_serr_pulse: assert property (serr_dev_oe |-> !serr_dev_o ##1 !serr_dev_oe)
        else $error("error pulse wrong");
    a_devsel_medium: assert property ($rose(mem_access)
        |-> !(devsel_dev_oe && !devsel_dev_o) ##1 (devsel_dev_oe && !devsel_dev_o))
        else $error("claim timing");
    a_reset_float: assert property (disable iff (1'b0) (sys_rst || $fell(sys_rst))
        |-> gnt_oe == 5'h0 && !bridge_hold_ack_oe && !keepalive_dev_oe
        && !devsel_dev_oe && !serr_dev_oe) else $error("output driven in reset");
    // Main scenarios reached
    c_hold: cover property (!bridge_hold_ack_n);
    c_serr: cover property (serr_dev_oe);
    c_claim: cover property (devsel_dev_oe);
endmodule : arb_link_properties

// ---- testbench.sv ----
// Testbench: both ends joined by the link interface, directed scenarios.
// Assumes: shared and open-drain lines are resolved here from the enables.
`timescale 1ns/1ns
module testbench;
    logic        clk_sys, sys_rst, cpu_lock_req, cpu_stop_req, clock_needed;
    logic        want_hold, drive_req, mem_req, bad_par, drive_d_reg;
    logic        wr_buf_empty, post_buf_empty, hold_active, parity_error;
    logic        hold_granted, stopped;
    logic [4:0]  want_bus, granted;
    logic [3:0]  cbe_in;
    logic [31:0] ad_in, cyc_reg;
    int          error_cnt, n_checks;
    arb_link_if link ();
    ////////////////////////////////////////////////////////////
    // Pull-ups on released lines, a moving pattern on idle data
    assign link.stop_n = (link.stop_dev_oe ? link.stop_dev_o : 1'b1)
        & (link.stop_far_oe ? link.stop_far_o : 1'b1);
    assign link.exclusive_access_n = !link.exclusive_dev_oe | link.exclusive_dev_o;
    assign link.bus_clock_keepalive_n = !link.keepalive_dev_oe | link.keepalive_dev_o;
    assign link.ad = link.drive_far ? link.ad_far_o : ~cyc_reg;
    assign link.cbe_n = link.drive_far ? link.cbe_far_o : cyc_reg[3:0];
    assign link.par = (drive_d_reg ? link.par_far_o : cyc_reg[0]) ^ bad_par;
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            cyc_reg     <= 32'h0;
            drive_d_reg <= 1'b0;
        end else begin
            cyc_reg     <= cyc_reg + 32'h1;
            drive_d_reg <= link.drive_far;
        end
    end
    arb_dev i_arb_dev (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link.dev),
        .cpu_lock_req(cpu_lock_req), .cpu_stop_req(cpu_stop_req),
        .clock_needed(clock_needed), .wr_buf_empty(wr_buf_empty),
        .post_buf_empty(post_buf_empty), .hold_active(hold_active),
        .parity_error(parity_error));
    arb_far i_arb_far (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link.far),
        .want_bus(want_bus), .want_hold(want_hold), .drive_req(drive_req),
        .ad_in(ad_in), .cbe_in(cbe_in), .mem_req(mem_req), .granted(granted),
        .hold_granted(hold_granted), .stopped(stopped));
    arb_link_properties i_arb_link_properties (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .req_n(link.req_n), .gnt_n(link.gnt_n), .gnt_oe(link.gnt_oe),
        .bridge_hold_req_n(link.bridge_hold_req_n),
        .bridge_hold_ack_n(link.bridge_hold_ack_n),
        .bridge_hold_ack_oe(link.bridge_hold_ack_oe), .drive_far(link.drive_far),
        .ad(link.ad), .cbe_n(link.cbe_n), .par_far_o(link.par_far_o),
        .mem_access(link.mem_access), .devsel_dev_o(link.devsel_dev_o),
        .devsel_dev_oe(link.devsel_dev_oe), .serr_dev_o(link.serr_dev_o),
        .serr_dev_oe(link.serr_dev_oe), .keepalive_dev_oe(link.keepalive_dev_oe));
    ////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test
    // Each master alone, then all at once
    task automatic t_grants();
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_sys) want_bus <= 5'h1 << i;
            tick(1);
            chk(link.gnt_n, 5'h1f ^ (5'h1 << i));
            tick(1);
            chk(granted, 5'h1 << i);
            @(posedge clk_sys) want_bus <= 5'h0;
            tick(3);
        end
        @(posedge clk_sys) want_bus <= 5'h1f;
        tick(2);
        chk($countones(~link.gnt_n), 1);
        @(posedge clk_sys) want_bus <= 5'h0;
        tick(3);
    endtask : t_grants
    // Hold sequence, a master refused meanwhile, then release
    task automatic t_hold();
        @(posedge clk_sys) want_hold <= 1'b1;
        tick(6);
        chk({wr_buf_empty, post_buf_empty}, 2'h2);
        tick(4);
        chk(link.bridge_hold_ack_n, 1'b1);
        tick(1);
        chk(link.bridge_hold_ack_n, 1'b0);
        chk({wr_buf_empty, post_buf_empty, hold_active}, 3'h7);
        @(posedge clk_sys) want_bus <= 5'h04;
        tick(4);
        chk({link.gnt_n, link.bridge_hold_ack_n, hold_granted}, 7'h7d);
        @(posedge clk_sys) want_hold <= 1'b0;
        tick(4);
        chk({link.gnt_n, link.bridge_hold_ack_n}, 6'h37);
        @(posedge clk_sys) want_bus <= 5'h0;
        tick(3);
    endtask : t_hold
    // Parity over data and command; last round corrupted on the wire
    task automatic t_parity();
        logic [35:0] tbl [3] = '{36'h3_a5c3_0f01, 36'hf_ffff_ffff, 36'h0_1234_5678};
        logic        seen;
        seen = 1'b0;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys) {cbe_in, ad_in} <= tbl[i];
            drive_req <= 1'b1;
            @(posedge clk_sys) drive_req <= 1'b0;
            @(posedge clk_sys) bad_par <= (i == 2);
            #1;
            chk(link.par_far_o, ^tbl[i]);
            @(posedge clk_sys) bad_par <= 1'b0;
            #1;
            // Error flags stand only for the cycle after the corrupt parity
            chk(parity_error, i == 2);
            chk(link.serr_dev_oe & !link.serr_dev_o, i == 2);
            if (i == 2) seen = link.serr_dev_oe & !link.serr_dev_o;
        end
        chk(seen, 1'b1);
    endtask : t_parity
    // Lock, stop, keepalive hold-off and memory claim
    task automatic t_side();
        @(posedge clk_sys) cpu_lock_req <= 1'b1;
        want_bus <= 5'h08;
        tick(1);
        chk(link.exclusive_access_n, 1'b0);
        chk(link.gnt_n, 5'h17);
        @(posedge clk_sys) cpu_lock_req <= 1'b0;
        want_bus <= 5'h00;
        cpu_stop_req <= 1'b1;
        tick(2);
        chk({link.stop_n, stopped}, 2'h1);
        @(posedge clk_sys) cpu_stop_req <= 1'b0;
        clock_needed <= 1'b1;
        tick(1);
        chk(link.bus_clock_keepalive_n, 1'b0);
        @(posedge clk_sys) clock_needed <= 1'b0;
        mem_req <= 1'b1;
        tick(1);
        chk(link.devsel_dev_oe & !link.devsel_dev_o, 1'b1);
        tick(6);
        chk(link.bus_clock_keepalive_n, 1'b0);
        tick(3);
        chk(link.bus_clock_keepalive_n, 1'b1);
        @(posedge clk_sys) mem_req <= 1'b0;
        tick(2);
    endtask : t_side
    // Reset in mid-run with grant, stop, lock and keepalive driven
    task automatic t_reset();
        @(posedge clk_sys) {cpu_lock_req, cpu_stop_req, clock_needed} <= 3'h7;
        want_bus <= 5'h02;
        tick(2);
        @(posedge clk_sys) sys_rst <= 1'b1;
        #1;
        chk(link.gnt_oe, 5'h0);
        chk({link.stop_n, link.exclusive_access_n, link.bus_clock_keepalive_n}, 3'h7);
        @(posedge clk_sys) {cpu_lock_req, cpu_stop_req, want_bus} <= 7'h0;
        @(posedge clk_sys) sys_rst <= 1'b0;
        #1;
        chk(link.bus_clock_keepalive_n, 1'b1);
        @(posedge clk_sys) clock_needed <= 1'b0;
        tick(3);
    endtask : t_reset
    ////////////////////////////////////////////////////////////
    // Clock and main sequence
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        {sys_rst, cpu_lock_req, cpu_stop_req, clock_needed, bad_par} = 5'h10;
        {want_bus, want_hold, drive_req, mem_req, ad_in, cbe_in} = 44'h0;
        {error_cnt, n_checks} = '0;
        tick(15);
        chk(link.gnt_n, 5'h1f);
        @(posedge clk_sys) sys_rst <= 1'b0;
        tick(2);
        t_grants();
        t_hold();
        t_parity();
        t_side();
        t_reset();
        stop_test();
    end
endmodule : testbench
